/* hdl/pecs_regs.v */
`timescale 1ns/1ps
`include "pecs_defines.vh"

module pecs_regs #(
   parameter NPORTS = 2
)(
   input wire clock,
   input wire resetn,
   input wire clk_en,
   input wire wr_en,
   input wire rd_en,
   input wire [$clog2(NPORTS > 1 ? NPORTS : 2)-1:0] port_addr,
   input wire [4:0] reg_addr,
   input wire [15:0] wr_data,
   input wire [NPORTS-1:0] eof_error_evt,
   input wire [NPORTS-1:0] disconnect_evt,
   input wire [NPORTS-1:0] link_integrity_ok,
   input wire [NPORTS-1:0] full_duplex,
   input wire [NPORTS-1:0] rx_active,
   input wire [NPORTS-1:0] tx_active,
   output reg [15:0] rd_data,
   output reg rd_valid,
   output reg [NPORTS-1:0] link_pass,
   output reg [NPORTS-1:0] jabber_en,
   output reg [NPORTS-1:0] echo_en,
   output reg [NPORTS-1:0] heartbeat_test_en,
   output reg [2*NPORTS-1:0] squelch_sel,
   output reg [NPORTS-1:0] carrier_sense,
   output reg [6*NPORTS-1:0] op_mode,
   output reg [NPORTS-1:0] soft_reset_pulse
);

   // Port index width, one bit at least
   localparam AW = $clog2(NPORTS > 1 ? NPORTS : 2);

   // ****************************************
   // Broadcast decision
   // ****************************************
   // Broadcast follows the addressed port's bit
   wire [NPORTS-1:0] bcast_vec;
   wire bcast_on = bcast_vec[port_addr];
   // One 16-bit read image per port
   wire [16*NPORTS-1:0] rd_vec;

   // ****************************************
   // Per-port register slices
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NPORTS; g = g + 1)
      begin : g_port
         localparam [AW-1:0] PIDX = g;
         // ****************************************
         // Write decode
         // ****************************************
         reg force_link_q, jab_dis_q, echo_dis_q, hb_dis_q, retain_q, bcast_q;
         reg [1:0] squelch_q, cs_sel_q;
         reg eof_q, disc_q;
         reg [5:0] mode_act_q, mode_pend_q;
         wire sel = bcast_on || (port_addr == PIDX);
         wire wr = clk_en && wr_en && sel;
         wire rd_me = clk_en && rd_en && (port_addr == PIDX);
         wire wr_tb = wr && (reg_addr == `PECS_REG_TBCS);
         wire wr_e1 = wr && (reg_addr == `PECS_REG_EPC1);
         // Soft reset rides on a write of the basic control register
         wire srst = wr && (reg_addr == `PECS_REG_BMCR) && wr_data[`PECS_BMCR_SRST];
         wire rd_tb = rd_me && (reg_addr == `PECS_REG_TBCS);
         wire [15:0] wd = wr_data;
         wire lnk = force_link_q | link_integrity_ok[g];
         reg cs_d;

         // ****************************************
         // Carrier-sense source
         // ****************************************
         // Duplex picks how the select code is read
         always @*
         begin
            cs_d = 1'b0;
            case ({full_duplex[g], cs_sel_q})
               3'h0, 3'h1:
                  cs_d = rx_active[g] | tx_active[g];
               3'h2, 3'h3:
                  cs_d = rx_active[g];
               3'h4, 3'h6:
                  cs_d = rx_active[g];
               3'h5, 3'h7:
                  cs_d = 1'b0;
               default:
                  cs_d = 1'b0;
            endcase
         end

         // ****************************************
         // Sticky control bits
         // ****************************************
         // Sticky bits fall back only when retention is off
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
            begin
               {force_link_q, jab_dis_q, echo_dis_q, hb_dis_q, squelch_q} <=
                  `PECS_TBCS_STICKY_RST;
            end
            else if (clk_en)
            begin
               if (wr_tb)
               begin
                  force_link_q <= wd[`PECS_FORCE_LINK];
                  jab_dis_q <= wd[`PECS_JAB_DIS];
                  echo_dis_q <= wd[`PECS_ECHO_DIS];
                  hb_dis_q <= wd[`PECS_HB_DIS];
                  squelch_q <= wd[`PECS_SQ_HI:`PECS_SQ_LO];
               end
               else if (srst && !retain_q)
               begin
                  {force_link_q, jab_dis_q, echo_dis_q, hb_dis_q, squelch_q} <=
                     `PECS_TBCS_STICKY_RST;
               end
            end
         end

         // Super-sticky: software reset never touches it
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               retain_q <= `PECS_RETAIN_RST;
            else if (clk_en && wr_tb)
               retain_q <= wd[`PECS_RETAIN];
         end

         // Broadcast enable is sticky like the controls
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               bcast_q <= `PECS_BCAST_RST;
            else if (clk_en)
            begin
               if (wr_tb)
                  bcast_q <= wd[`PECS_BCAST];
               else if (srst && !retain_q)
                  bcast_q <= `PECS_BCAST_RST;
            end
         end

         // Written only from the management side
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               cs_sel_q <= `PECS_CS_RST;
            else if (clk_en && wr_tb)
               cs_sel_q <= wd[`PECS_CS_HI:`PECS_CS_LO];
         end

         // ****************************************
         // Self-clearing event flags
         // ****************************************
         // New event beats the read that clears
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
            begin
               eof_q <= `PECS_FLAG_RST;
               disc_q <= `PECS_FLAG_RST;
            end
            else if (clk_en)
            begin
               eof_q <= eof_error_evt[g] | (eof_q & ~rd_tb);
               disc_q <= disconnect_evt[g] | (disc_q & ~rd_tb);
            end
         end

         // ****************************************
         // Operating mode, pending and in force
         // ****************************************
         // Mode written now, applied at the next software reset
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               mode_pend_q <= `PECS_MODE_RST;
            else if (clk_en && wr_e1)
               mode_pend_q <= wd[`PECS_MODE_HI:`PECS_MODE_LO];
         end

         // Pending value moves in only on software reset
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               mode_act_q <= `PECS_MODE_RST;
            else if (clk_en && srst)
               mode_act_q <= mode_pend_q;
         end

         assign bcast_vec[g] = bcast_q;

         // ****************************************
         // Per-port read image
         // ****************************************
         // Unmapped registers and reserved bits read as zero
         reg [15:0] img_d;
         always @*
         begin
            img_d = 16'h0000;
            case (reg_addr)
               `PECS_REG_TBCS:
               begin
                  img_d[`PECS_FORCE_LINK] = force_link_q;
                  img_d[`PECS_JAB_DIS] = jab_dis_q;
                  img_d[`PECS_ECHO_DIS] = echo_dis_q;
                  img_d[`PECS_HB_DIS] = hb_dis_q;
                  img_d[`PECS_SQ_HI:`PECS_SQ_LO] = squelch_q;
                  img_d[`PECS_RETAIN] = retain_q;
                  img_d[`PECS_EOF_ERR] = eof_q;
                  img_d[`PECS_DISC] = disc_q;
                  img_d[`PECS_LINK] = lnk;
                  img_d[`PECS_CS_HI:`PECS_CS_LO] = cs_sel_q;
                  img_d[`PECS_BCAST] = bcast_q;
               end
               `PECS_REG_EPC1:
                  img_d[`PECS_MODE_HI:`PECS_MODE_LO] = mode_act_q;
               default:
                  img_d = 16'h0000;
            endcase
         end
         assign rd_vec[16*g +: 16] = img_d;

         // ****************************************
         // Controls toward the 10BASE-T side
         // ****************************************
         // Registered so each pin leaves a flip-flop
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               link_pass[g] <= 1'b0;
            else if (clk_en)
               link_pass[g] <= lnk;
         end

         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               jabber_en[g] <= 1'b1;
            else if (clk_en)
               jabber_en[g] <= ~jab_dis_q;
         end

         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               echo_en[g] <= 1'b0;
            else if (clk_en)
               echo_en[g] <= ~echo_dis_q;
         end

         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               heartbeat_test_en[g] <= 1'b0;
            else if (clk_en)
               heartbeat_test_en[g] <= ~hb_dis_q;
         end

         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               squelch_sel[2*g +: 2] <= `PECS_SQ_NORMAL;
            else if (clk_en)
               squelch_sel[2*g +: 2] <= squelch_q;
         end

         // ****************************************
         // Carrier sense
         // ****************************************
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               carrier_sense[g] <= 1'b0;
            else if (clk_en)
               carrier_sense[g] <= cs_d;
         end

         // ****************************************
         // Mode in force and reset strobe
         // ****************************************
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               op_mode[6*g +: 6] <= `PECS_MODE_RST;
            else if (clk_en)
               op_mode[6*g +: 6] <= mode_act_q;
         end

         // One-cycle strobe for the rest of the port
         always @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               soft_reset_pulse[g] <= 1'b0;
            else if (clk_en)
               soft_reset_pulse[g] <= srst;
         end
      end
   endgenerate

   // ****************************************
   // Read port
   // ****************************************
   // Reads see the addressed port only, even in broadcast
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
      end
      else if (clk_en)
      begin
         rd_valid <= rd_en;
         if (rd_en)
            rd_data <= rd_vec[16*port_addr +: 16];
      end
   end

endmodule // pecs_regs

/* pkg/pecs_defines.vh */
`ifndef PECS_DEFINES_VH
`define PECS_DEFINES_VH
// ****************************************
// Register indices
// ****************************************
`define PECS_REG_TBCS 5'h16
`define PECS_REG_EPC1 5'h17
`define PECS_REG_BMCR 5'h00
`define PECS_BMCR_SRST 15
// ****************************************
// Fields of the 10BASE-T control/status register
// ****************************************
`define PECS_FORCE_LINK 15
`define PECS_JAB_DIS 14
`define PECS_ECHO_DIS 13
`define PECS_HB_DIS 12
`define PECS_SQ_HI 11
`define PECS_SQ_LO 10
`define PECS_RETAIN 9
`define PECS_EOF_ERR 8
`define PECS_DISC 7
`define PECS_LINK 6
`define PECS_CS_HI 2
`define PECS_CS_LO 1
`define PECS_BCAST 0
// Sticky defaults
`define PECS_TBCS_STICKY_RST 6'h0c
`define PECS_RETAIN_RST 1'b1
`define PECS_BCAST_RST 1'b0
`define PECS_CS_RST 2'h0
`define PECS_FLAG_RST 1'b0
`define PECS_TBCS_WMASK 16'hfe07
// ****************************************
// Extended port control one
// ****************************************
`define PECS_MODE_HI 13
`define PECS_MODE_LO 8
`define PECS_MODE_RST 6'h00
`define PECS_EPC1_WMASK 16'h3f00
// Squelch select codes
`define PECS_SQ_NORMAL 2'h0
`define PECS_SQ_LOW 2'h1
`define PECS_SQ_HIGH 2'h2
`endif

/* verification/pecs_mgmt_model.sv */
`timescale 1ns/1ps
module pecs_mgmt_model (
   input wire clock,
   output logic wr_en,
   output logic rd_en,
   output logic [0:0] port_addr,
   output logic [4:0] reg_addr,
   output logic [15:0] wr_data
);
   // ****
   // Management requests
   // ****
   initial {wr_en, rd_en, port_addr, reg_addr, wr_data} = 24'h000000;
   // Idle cycle after each request; released data is inverted, not held
   task automatic xfer(logic w, logic [0:0] p, logic [4:0] a, logic [15:0] d);
      @(negedge clock);
      {wr_en, rd_en, port_addr, reg_addr, wr_data} <= {w, !w, p, a, d};
      @(negedge clock);
      {wr_en, rd_en} <= 2'b00;
      wr_data <= ~d;
   endtask
   task automatic srst(logic [0:0] p);
      xfer(1'b1, p, 5'h00, 16'h8000);
   endtask
endmodule // pecs_mgmt_model

/* verification/pecs_regs_checker.sv */
`timescale 1ns/1ps
module pecs_regs_checker #(
   parameter NPORTS = 2
)(
   input wire clock,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [$clog2(NPORTS > 1 ? NPORTS : 2)-1:0] port_addr,
   input wire [4:0] reg_addr,
   input wire [15:0] wr_data,
   input wire [NPORTS-1:0] link_integrity_ok,
   input wire [15:0] rd_data,
   input wire rd_valid,
   input wire [NPORTS-1:0] link_pass,
   input wire [NPORTS-1:0] jabber_en,
   input wire [NPORTS-1:0] echo_en,
   input wire [2*NPORTS-1:0] squelch_sel,
   input wire [6*NPORTS-1:0] op_mode,
   input wire [NPORTS-1:0] soft_reset_pulse
);
   // ****
   // Port 0 properties
   // ****
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // Isolated write, so the next write cannot mask the effect
   sequence wr16;
      wr_en && reg_addr == 5'h16 && port_addr == 0 ##1 !wr_en;
   endsequence
   read_answer_a: assert property (rd_valid == $past(rd_en))
      else $error("read answer timing");
   link_status_a: assert property ($past(resetn) && $past(link_integrity_ok[0]) |-> link_pass[0])
      else $error("link pass missing");
   jabber_ctl_a: assert property (wr16 |=> jabber_en[0] == !$past(wr_data[14], 2))
      else $error("jabber enable wrong");
   echo_ctl_a: assert property (wr16 |=> echo_en[0] == !$past(wr_data[13], 2))
      else $error("echo enable wrong");
   squelch_ctl_a: assert property (wr16 |=> squelch_sel[1:0] == $past(wr_data[11:10], 2))
      else $error("squelch select wrong");
   srst_pulse_a: assert property (soft_reset_pulse[0] |=> !soft_reset_pulse[0])
      else $error("reset pulse too long");
   mode_hold_a: assert property ($changed(op_mode[5:0]) |-> soft_reset_pulse[0] || $past(soft_reset_pulse[0]))
      else $error("mode changed without reset");
   unmapped_zero_a: assert property (rd_en && reg_addr == 5'h05 |=> rd_data == 16'h0000)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (rd_valid && $past(reg_addr) == 5'h16 |-> rd_data[5:3] == 3'h0)
      else $error("reserved bits not zero");
   cover property (rd_valid && rd_data[8]);
   cover property (soft_reset_pulse[0]);
   cover property ($changed(op_mode[5:0]));
endmodule // pecs_regs_checker
bind pecs_regs pecs_regs_checker #(.NPORTS(NPORTS)) u_chk (.*);

/* verification/phy_extended_control_status_regs_bench.sv */
`timescale 1ns/1ps
module phy_extended_control_status_regs_bench;
   // ****
   // Bench
   // ****
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] eof = 2'b00, disc = 2'b00, lok = 2'b00, fdx = 2'b00, rxa = 2'b00, txa = 2'b00;
   wire wr_en, rd_en, rd_valid;
   wire [0:0] pa;
   wire [4:0] ra;
   wire [15:0] wd, rd_data;
   wire [1:0] lp, je, ee, he, csense, srp;
   wire [3:0] sq;
   wire [11:0] om;
   int err_total = 0, n_tests = 0;
   logic [15:0] exp_q[$], msk_q[$];
   logic [15:0] r, cur;
   always #2 clock = ~clock;
   pecs_mgmt_model u_mgmt (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .port_addr(pa),
      .reg_addr(ra), .wr_data(wd));
   pecs_regs #(.NPORTS(2)) i_pecs_regs (.clock(clock), .resetn(resetn), .clk_en(1'b1),
      .wr_en(wr_en), .rd_en(rd_en), .port_addr(pa), .reg_addr(ra), .wr_data(wd),
      .eof_error_evt(eof), .disconnect_evt(disc), .link_integrity_ok(lok), .full_duplex(fdx),
      .rx_active(rxa), .tx_active(txa), .rd_data(rd_data), .rd_valid(rd_valid), .link_pass(lp),
      .jabber_en(je), .echo_en(ee), .heartbeat_test_en(he), .squelch_sel(sq),
      .carrier_sense(csense), .op_mode(om), .soft_reset_pulse(srp));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(logic [0:0] p, logic [4:0] a, logic [15:0] e, logic [15:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      u_mgmt.xfer(1'b0, p, a, 16'h0000);
   endtask
   task automatic complete_run();
      $display("tests %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(negedge clock)
      if (rd_valid === 1'b1)
         chk("rd_data", exp_q.pop_front(), rd_data & msk_q.pop_front());
   initial
   begin
      repeat (12) @(negedge clock);
      resetn = 1'b1;
      r = 16'($urandom(32'hfa42));
      rd(1'b0, 5'h16, 16'h3200, 16'hffff);
      chk("reset ctl", 16'h0300, {6'h00, je, ee, he, sq});
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         r = (16'($urandom()) & 16'hf1f8) | {4'h0, 2'(i % 3), 7'h40, i[1:0], 1'b0};
         {fdx[0], rxa[0], txa[0]} = {i[2], 2'($urandom())};
         u_mgmt.xfer(1'b1, 1'b0, 5'h16, r);
         @(negedge clock);
         cur = (r & 16'hfe07) | {9'h000, r[15], 6'h00};
         chk("ctl", {6'h00, 1'b1, ~r[14], 1'b0, ~r[13], 1'b0, ~r[12], 2'b00, r[11:10]},
            {6'h00, je, ee, he, sq});
         chk("link", {15'h0000, r[15]}, {15'h0000, lp[0]});
         chk("csense", {15'h0000, i[2] ? rxa[0] & !r[1] : rxa[0] | txa[0] & !r[2]},
            {15'h0000, csense[0]});
         rd(1'b0, 5'h16, cur, 16'hffff);
      end
      $display("test controls done");
      eof[0] = 1'b1;
      disc[0] = 1'b1;
      @(negedge clock);
      eof = 2'b00;
      disc = 2'b00;
      rd(1'b0, 5'h16, cur | 16'h0180, 16'hffff);
      rd(1'b0, 5'h16, cur, 16'hffff);
      rd(1'b0, 5'h05, 16'h0000, 16'hffff);
      $display("test flags done");
      r = (16'($urandom()) & 16'h3f00) | 16'h0100;
      u_mgmt.xfer(1'b1, 1'b0, 5'h17, r);
      rd(1'b0, 5'h17, 16'h0000, 16'hffff);
      u_mgmt.srst(1'b0);
      @(negedge clock);
      chk("mode", r >> 8, {4'h0, om});
      rd(1'b0, 5'h17, r, 16'hffff);
      rd(1'b0, 5'h16, cur, 16'hfff9);
      u_mgmt.xfer(1'b1, 1'b0, 5'h16, cur & 16'hfdff);
      u_mgmt.srst(1'b0);
      rd(1'b0, 5'h16, 16'h3000, 16'hfff9);
      $display("test soft reset done");
      r = (16'($urandom()) & 16'hf000) | 16'h0201;
      u_mgmt.xfer(1'b1, 1'b0, 5'h16, r);
      u_mgmt.xfer(1'b1, 1'b0, 5'h16, r ^ 16'hc000);
      @(negedge clock);
      chk("bcast", {14'h0000, r[14], r[14]}, {14'h0000, je});
      u_mgmt.xfer(1'b1, 1'b0, 5'h16, r & 16'hfffe);
      u_mgmt.xfer(1'b1, 1'b0, 5'h16, 16'h3200);
      rd(1'b1, 5'h16, r & 16'hffbe, 16'hffbf);
      rd(1'b0, 5'h16, 16'h3200, 16'hffbf);
      lok = 2'b11;
      repeat (2) @(negedge clock);
      chk("link", 16'h0003, {14'h0000, lp});
      $display("test broadcast done");
      for (int k = 0; k < 8 && exp_q.size() != 0; k++)
         @(negedge clock);
      if (exp_q.size() != 0)
         err_total++;
      complete_run();
   end
endmodule // phy_extended_control_status_regs_bench
